//--- src/adcs_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, clk_i is the device oscillator
// Notes:   Included by name only; definitions only
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCS_OFF_CTRL     3'h0
`define ADCS_OFF_PCFG     3'h1
`define ADCS_OFF_RES      3'h2
`define ADCS_OFF_STAT     3'h3
`define ADCS_OFF_PORT     3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCS_CTRL_ON      0
`define ADCS_CTRL_GO      2
`define ADCS_CTRL_CHS     3
`define ADCS_CTRL_CS      6
`define ADCS_STAT_FLAG    0
`define ADCS_STAT_IE      1
`define ADCS_STAT_SUSP    2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ADCS_RST_CS       2'h0
`define ADCS_RST_CHS      3'h0
`define ADCS_RST_PCFG     2'h0
`define ADCS_CS_RC        2'h3

// ----------------------------------------------------------------
// Timing (ns) and derived counts
// ----------------------------------------------------------------
`define ADCS_CLK_NS       50
`define ADCS_TAD_MIN_NS   1600
`define ADCS_RC_TAD_NS    4000
`define ADCS_INSTR_NS     200
`define ADCS_INSTR_CYC    ((`ADCS_INSTR_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_RC_HALF_CYC  (`ADCS_RC_TAD_NS / (2 * `ADCS_CLK_NS))
`define ADCS_LEAD_HALVES  4
`define ADCS_CONV_HALVES  19
`define ADCS_POST_HALVES  4

`endif

//--- src/adcs_pkg.sv
// Purpose: Types shared by the conversion sequencer files
// Assumes: Constants come from adcs_params.svh
// Notes:   Structs carry the register port and analog controls
package adcs_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_ACQ,
        ST_DLY,
        ST_CONV,
        ST_POST
    } adcs_state_t;

    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcs_bus_req_t;

    // Controls toward the analog core
    typedef struct packed {
        logic       power;
        logic       sample;
        logic [2:0] channel;
        logic [7:0] code;
    } adcs_ana_t;

endpackage : adcs_pkg

//--- src/adcs_sequencer.sv
// Purpose: Successive-approximation conversion sequencer with registers
// Assumes: Analog core answers cmp_i for the trial code on ana_o.code
// Notes:   8-bit register port, read data valid one cycle after strobe
//
// Behaviour
// RQ1 - Full conversion lasts nine and half periods
// RQ2 - Select 00/01/10 divide 2/8/32, 11 RC
// RQ3 - Software keeps bit period above the minimum
// RQ4 - RC source gives about 4 us period
// RQ5 - Analog pins read as zero on port
// RQ6 - Software sets analog pins as inputs
// RQ7 - Software starts in a later write than power-on
// RQ8 - Clearing go aborts running conversion immediately
// RQ9 - Abort never writes partial bits to result
// RQ10 - After abort wait two periods, then acquire
// RQ11 - Two period lead-in, one bit per period
// RQ12 - Mid-conversion select changes stay off RC
// RQ13 - RC start delayed one instruction cycle
// RQ14 - Sleep completion clears go, loads result
// RQ15 - Sleep completion with interrupt enabled wakes
// RQ16 - Sleep completion without interrupt powers down
// RQ17 - Sleep on non-RC aborts and powers down
// RQ18 - Sleep conversion: select RC, go, sleep
// RQ19 - Completion loads result, clears go, sets flag
// RQ20 - Capacitor held off two periods after conversion
// RQ21 - Port field chooses analog pins and reference
// RQ22 - Reset turns off, aborts, keeps result
// RQ23 - Go ignored while converter is off
// RQ24 - Free-running divider follows select at ticks
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"

module adcs_sequencer #(
    parameter int RC_HALF = `ADCS_RC_HALF_CYC
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // Register port
    input  wire adcs_pkg::adcs_bus_req_t bus_i,
    output logic [7:0]                 rdata_o,
    // Device state and port pins
    input  wire logic                  sleep_i,
    input  wire logic [4:0]            pin_i,
    output logic [3:0]                 pin_analog_o,
    output logic                       vref_ext_o,
    // Analog core
    input  wire logic                  cmp_i,
    output adcs_pkg::adcs_ana_t        ana_o,
    // Events
    output logic                       conv_done_flag_o,
    output logic                       wake_o
);
    import adcs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    adcs_state_t st_r, st_nxt;
    logic [4:0]  hc_r, hc_nxt;
    logic [1:0]  conv_clock_select_r;
    logic [2:0]  channel_select_r;
    logic        converter_power_on_r;
    logic        go_r;
    logic [1:0]  port_config_field_r;
    logic [7:0]  conversion_result_r;
    logic [7:0]  code_r;
    logic        conv_done_flag_r;
    logic        conv_irq_enable_r;
    logic        suspect_r;
    logic        pwr_dn_r;
    logic        wake_r;
    logic [7:0]  rdata_r;
    logic        half_tick;
    logic        period_ok;

    // ----------------------------------------------------------------
    // Bit period ticks
    // ----------------------------------------------------------------
    adcs_tick_gen #(
        .RC_HALF             (RC_HALF)
    ) u_tick (
        .clk_i               (clk_i),
        .rst_b_i             (rst_b_i),
        .conv_clock_select_i (conv_clock_select_r),
        .half_tick_o         (half_tick),
        .period_ok_o         (period_ok)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Result bit position for a half count
    function automatic logic [2:0] bit_pos(input logic [4:0] h);
        bit_pos = (h == 5'(`ADCS_CONV_HALVES)) ? 3'h0
                : 3'(5'h07 - ((h - 5'(`ADCS_LEAD_HALVES) - 5'h02) >> 1));
    endfunction : bit_pos

    wire       wr_ctrl = bus_i.wr && bus_i.addr == `ADCS_OFF_CTRL;
    wire       wr_pcfg = bus_i.wr && bus_i.addr == `ADCS_OFF_PCFG;
    wire       wr_res  = bus_i.wr && bus_i.addr == `ADCS_OFF_RES;
    wire       wr_stat = bus_i.wr && bus_i.addr == `ADCS_OFF_STAT;
    wire       w_go    = bus_i.wdata[`ADCS_CTRL_GO];
    wire       on_nxt  = wr_ctrl ? bus_i.wdata[`ADCS_CTRL_ON] : converter_power_on_r;
    wire [1:0] cs_nxt  = wr_ctrl ? bus_i.wdata[`ADCS_CTRL_CS +: 2] : conv_clock_select_r;
    wire       busy    = (st_r == ST_DLY) || (st_r == ST_CONV);
    wire [4:0] hc_inc  = hc_r + 5'h01;

    // Start only from acquisition with the converter already on
    wire start    = wr_ctrl && w_go && converter_power_on_r && !pwr_dn_r
                 && st_r == ST_ACQ; // RQ23
    wire abort_sw = wr_ctrl && !w_go && busy; // RQ8
    wire non_rc   = conv_clock_select_r != `ADCS_CS_RC;
    wire abort_sl = sleep_i && non_rc && busy; // RQ17
    wire abort    = abort_sw || abort_sl || (busy && !on_nxt);
    wire done_evt = st_r == ST_CONV && half_tick
                 && hc_inc == 5'(`ADCS_CONV_HALVES) && !abort; // RQ1
    wire bit_evt  = st_r == ST_CONV && half_tick && !abort
                 && hc_inc >= 5'(`ADCS_LEAD_HALVES + 2)
                 && (!hc_inc[0] || hc_inc == 5'(`ADCS_CONV_HALVES)); // RQ11
    wire [2:0] bp       = bit_pos(hc_inc);
    wire [7:0] bit_mask = 8'h01 << bp;
    wire [7:0] code_dec = (cmp_i ? code_r : (code_r & ~bit_mask)) | (bit_mask >> 1);
    wire post_end = st_r == ST_POST && half_tick
                 && hc_inc == 5'(`ADCS_POST_HALVES); // RQ10 RQ20

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        hc_nxt = hc_r;
        if (!on_nxt) begin
            st_nxt = ST_ACQ;
            hc_nxt = 5'h00;
        end else if (abort) begin
            st_nxt = ST_POST; // RQ10
            hc_nxt = 5'h00;
        end else begin
            unique case (st_r)
                ST_ACQ: begin
                    if (start) begin
                        st_nxt = (cs_nxt == `ADCS_CS_RC) ? ST_DLY : ST_CONV; // RQ13
                        hc_nxt = 5'h00;
                    end
                end
                ST_DLY: begin
                    hc_nxt = hc_inc;
                    if (hc_inc == 5'(`ADCS_INSTR_CYC)) begin
                        st_nxt = ST_CONV; // RQ13
                        hc_nxt = 5'h00;
                    end
                end
                ST_CONV: begin
                    if (done_evt) begin
                        st_nxt = ST_POST; // RQ20
                        hc_nxt = 5'h00;
                    end else if (half_tick) begin
                        hc_nxt = hc_inc;
                    end
                end
                ST_POST: begin
                    if (post_end) begin
                        st_nxt = ST_ACQ;
                        hc_nxt = 5'h00;
                    end else if (half_tick) begin
                        hc_nxt = hc_inc;
                    end
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ST_ACQ; // RQ22
            hc_r <= 5'h00;
        end else begin
            st_r <= st_nxt;
            hc_r <= hc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_clock_select_r  <= `ADCS_RST_CS;
            channel_select_r     <= `ADCS_RST_CHS;
            converter_power_on_r <= 1'b0; // RQ22
            port_config_field_r  <= `ADCS_RST_PCFG;
        end else begin
            if (wr_ctrl) begin
                conv_clock_select_r  <= bus_i.wdata[`ADCS_CTRL_CS +: 2];
                channel_select_r     <= bus_i.wdata[`ADCS_CTRL_CHS +: 3];
                converter_power_on_r <= bus_i.wdata[`ADCS_CTRL_ON];
            end
            if (wr_pcfg) begin
                port_config_field_r <= bus_i.wdata[1:0];
            end
        end
    end

    // Go flag follows start, completion and abort
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            go_r <= 1'b0;
        end else begin
            go_r <= start || (go_r && !(done_evt || abort)); // RQ19 RQ14 RQ23
        end
    end

    // ----------------------------------------------------------------
    // Successive approximation and result
    // ----------------------------------------------------------------
    // Trial code: all decided bits plus the bit under test
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            code_r <= 8'h80;
        end else if (start) begin
            code_r <= 8'h80;
        end else if (bit_evt) begin
            code_r <= code_dec; // RQ11
        end
    end

    // Result keeps its value through reset and abort
    always_ff @(posedge clk_i) begin
        if (done_evt) begin
            conversion_result_r <= code_dec; // RQ19 RQ9
        end else if (wr_res) begin
            conversion_result_r <= bus_i.wdata;
        end
    end

    // Bits decided on a too-short period are marked suspect
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            suspect_r <= 1'b0;
        end else if (start) begin
            suspect_r <= 1'b0;
        end else if (bit_evt && !period_ok) begin
            suspect_r <= 1'b1; // RQ11
        end
    end

    // ----------------------------------------------------------------
    // Status, sleep and wake
    // ----------------------------------------------------------------
    wire sleep_done = done_evt && sleep_i;
    wire pd_set     = (sleep_i && non_rc) || (sleep_done && !conv_irq_enable_r);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_done_flag_r  <= 1'b0;
            conv_irq_enable_r <= 1'b0;
            pwr_dn_r          <= 1'b0;
            wake_r            <= 1'b0;
        end else begin
            // Set wins over a software clear
            conv_done_flag_r  <= done_evt
                              || (wr_stat ? bus_i.wdata[`ADCS_STAT_FLAG]
                                          : conv_done_flag_r); // RQ19
            if (wr_stat) begin
                conv_irq_enable_r <= bus_i.wdata[`ADCS_STAT_IE];
            end
            pwr_dn_r <= pd_set || (pwr_dn_r && sleep_i); // RQ16 RQ17
            wake_r   <= sleep_done && conv_irq_enable_r; // RQ15
        end
    end

    // ----------------------------------------------------------------
    // Port configuration and outputs
    // ----------------------------------------------------------------
    assign pin_analog_o = (port_config_field_r == 2'h0) ? 4'hf
                        : (port_config_field_r == 2'h1) ? 4'h7
                        : (port_config_field_r == 2'h2) ? 4'h3 : 4'h0; // RQ21
    assign vref_ext_o   = port_config_field_r == 2'h1; // RQ21
    wire [3:0] zero_msk = pin_analog_o | {vref_ext_o, 3'h0};
    wire [7:0] port_rd  = {3'h0, pin_i[4], pin_i[3:0] & ~zero_msk}; // RQ5

    assign ana_o.power   = converter_power_on_r && !pwr_dn_r; // RQ16 RQ17
    assign ana_o.sample  = ana_o.power && st_r == ST_ACQ; // RQ20
    assign ana_o.channel = channel_select_r;
    assign ana_o.code    = st_r == ST_CONV ? code_r : conversion_result_r;
    assign conv_done_flag_o = conv_done_flag_r;
    assign wake_o           = wake_r;

    // Read mux; unmapped offsets read zero
    wire [7:0] ctrl_rd = {conv_clock_select_r, channel_select_r, go_r,
                          1'b0, converter_power_on_r};
    wire [7:0] stat_rd = {5'h00, suspect_r, conv_irq_enable_r, conv_done_flag_r};
    wire [7:0] rd_mux  = (bus_i.addr == `ADCS_OFF_CTRL) ? ctrl_rd
                       : (bus_i.addr == `ADCS_OFF_PCFG) ? {6'h00, port_config_field_r}
                       : (bus_i.addr == `ADCS_OFF_RES)  ? conversion_result_r
                       : (bus_i.addr == `ADCS_OFF_STAT) ? stat_rd
                       : (bus_i.addr == `ADCS_OFF_PORT) ? port_rd : 8'h00;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus_i.rd ? rd_mux : 8'h00;
        end
    end
    assign rdata_o = rdata_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_rc_wait;
        (st_r == ST_DLY)[*4] ##1 (st_r == ST_CONV);
    endsequence

    property p_done;
        @(posedge clk_i) disable iff (!rst_b_i)
        done_evt |=> !go_r && conv_done_flag_r && st_r == ST_POST;
    endproperty
    a_done: assert property (p_done) // RQ19
        else $error("completion did not clear go and set flag");

    property p_abort;
        @(posedge clk_i) disable iff (!rst_b_i)
        (abort_sw && on_nxt) |=> !go_r && st_r == ST_POST && hc_r == 5'h00;
    endproperty
    a_abort: assert property (p_abort) // RQ8
        else $error("abort did not stop conversion");

    property p_keep;
        @(posedge clk_i) disable iff (!rst_b_i)
        (abort && !wr_res) |=> $stable(conversion_result_r);
    endproperty
    a_keep: assert property (p_keep) // RQ9
        else $error("result changed on abort");

    property p_post_off;
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_r == ST_POST && hc_r < 5'(`ADCS_POST_HALVES - 1) && on_nxt)
            |=> st_r == ST_POST && !ana_o.sample;
    endproperty
    a_post_off: assert property (p_post_off) // RQ20
        else $error("capacitor connected during post wait");

    property p_post_end;
        @(posedge clk_i) disable iff (!rst_b_i)
        (post_end && on_nxt) |=> st_r == ST_ACQ;
    endproperty
    a_post_end: assert property (p_post_end) // RQ10
        else $error("acquisition not resumed after wait");

    property p_ignore;
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_ctrl && w_go && !converter_power_on_r && !go_r) |=> !go_r;
    endproperty
    a_ignore: assert property (p_ignore) // RQ23
        else $error("go accepted while off");

    property p_rc_delay;
        @(posedge clk_i) disable iff (!rst_b_i || abort || !on_nxt)
        (start && cs_nxt == `ADCS_CS_RC) |=> s_rc_wait;
    endproperty
    a_rc_delay: assert property (p_rc_delay) // RQ13
        else $error("RC start delay wrong");

    property p_sleep_abort;
        @(posedge clk_i) disable iff (!rst_b_i)
        (abort_sl && !wr_ctrl) |=> !go_r && !ana_o.power && converter_power_on_r;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) // RQ17
        else $error("sleep on non-RC did not abort");

    property p_wake;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_done && conv_irq_enable_r) |=> wake_o ##1 !wake_o;
    endproperty
    a_wake: assert property (p_wake) // RQ15
        else $error("no wake pulse");

    property p_sleep_off;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_done && !conv_irq_enable_r && !wr_ctrl)
            |=> !ana_o.power && converter_power_on_r && !wake_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off) // RQ16 RQ14
        else $error("no power down after sleep completion");

    property p_port;
        @(posedge clk_i) disable iff (!rst_b_i)
        (bus_i.rd && bus_i.addr == `ADCS_OFF_PORT)
            |=> (rdata_o[3:0] & $past(zero_msk)) == 4'h0;
    endproperty
    a_port: assert property (p_port) // RQ5
        else $error("analog pin read nonzero");

endmodule : adcs_sequencer
`default_nettype wire

//--- src/adcs_tick_gen.sv
// Purpose: Half bit_conversion_period tick from a free-running divider
// Assumes: clk_i is the device oscillator
// Notes:   Divide ratio is reloaded only at a tick boundary
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"

module adcs_tick_gen #(
    parameter int RC_HALF = `ADCS_RC_HALF_CYC
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Selection
    input  wire logic [1:0] conv_clock_select_i,
    // Ticks
    output logic            half_tick_o,
    output logic            period_ok_o
);

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    logic [7:0] cnt_r;
    logic [7:0] len_r;
    logic [7:0] len_nxt;

    // Half period in clocks for each select code
    function automatic logic [7:0] half_len(input logic [1:0] sel);
        unique case (sel)
            2'h0:    half_len = 8'h01;
            2'h1:    half_len = 8'h04;
            2'h2:    half_len = 8'h10;
            default: half_len = 8'(RC_HALF);
        endcase
    endfunction : half_len

    // Tick at the end of each half period
    assign half_tick_o = (cnt_r == len_r - 8'h01);
    assign len_nxt     = half_len(conv_clock_select_i); // RQ2 RQ4
    // Full period meets the minimum bit period
    assign period_ok_o = (32'(len_r) * 2 * `ADCS_CLK_NS) >= `ADCS_TAD_MIN_NS;

    // Count, reloading ratio at the boundary
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 8'h00;
            len_r <= 8'h01;
        end else if (half_tick_o) begin
            cnt_r <= 8'h00;
            len_r <= len_nxt; // RQ24
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_div32_gap;
        @(posedge clk_i) disable iff (!rst_b_i)
        (half_tick_o && len_r == 8'h10 && len_nxt == 8'h10)
            |=> (!half_tick_o)[*8];
    endproperty
    a_div32_gap: assert property (p_div32_gap) // RQ2
        else $error("divide-by-32 half period too short");

    property p_div2_gap;
        @(posedge clk_i) disable iff (!rst_b_i)
        (half_tick_o && len_nxt == 8'h01) |=> half_tick_o;
    endproperty
    a_div2_gap: assert property (p_div2_gap) // RQ24
        else $error("divide-by-2 tick not every clock");

endmodule : adcs_tick_gen
`default_nettype wire

//--- verif/adcs_analog_model.sv
// Purpose: Analog pins model answering the comparator of the sequencer
// Assumes: One fixed level per channel, picked by the low channel bits
// Notes:   An unpowered core gets a toggling answer, never a held one
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model #(
    parameter logic [31:0] LEVELS = 32'h013cffa5
) (
    input  wire logic                clk_i,
    input  wire adcs_pkg::adcs_ana_t ana_i,
    output logic                     cmp_o
);
    import adcs_pkg::*;
    logic       junk_r = 1'b0;
    logic [7:0] level;
    // Pin levels as seen with the pins set as inputs
    assign level = LEVELS[ana_i.channel[1:0]*8 +: 8];
    // Pattern that changes every cycle while the core is off
    always_ff @(posedge clk_i) begin
        junk_r <= ~junk_r;
    end
    // Keep the trial bit when the input is at or above the trial code
    assign cmp_o = ana_i.power ? (level >= ana_i.code) : junk_r;
endmodule : adcs_analog_model
`default_nettype wire

//--- verif/tb_adcs_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: RC half period shortened to 2 clocks
// Notes:   Register tasks follow the one-cycle strobe port
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"
module tb_adcs_sequencer;
    import adcs_pkg::*;
    localparam logic [2:0]  CTRL = `ADCS_OFF_CTRL;
    localparam logic [2:0]  RES  = `ADCS_OFF_RES;
    localparam logic [2:0]  STAT = `ADCS_OFF_STAT;
    localparam logic [31:0] LVLS = 32'h013cffa5;
    localparam logic [39:0] PEXP = 40'h1f_1c_10_10_00;
    localparam logic [39:0] AEXP = 40'h00_03_17_0f_00;
    logic          clk_i   = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          sleep_i = 1'b0;
    adcs_bus_req_t bus     = '0;
    logic [7:0]    rdata, v;
    logic [3:0]    pin_analog;
    logic          vref_ext, cmp, flag, wake;
    adcs_ana_t     ana;
    int            failures = 0, checked = 0, wakes = 0, cyc = 0, t0;
    int            hv[4] = '{1, 4, 16, 2};
    // Clock and event counters
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
    end
    adcs_sequencer #(.RC_HALF(2)) i_adcs_sequencer (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .bus_i(bus), .rdata_o(rdata), .sleep_i(sleep_i), .pin_i(5'h1f),
        .pin_analog_o(pin_analog), .vref_ext_o(vref_ext), .cmp_i(cmp), .ana_o(ana),
        .conv_done_flag_o(flag), .wake_o(wake));
    adcs_analog_model #(.LEVELS(LVLS)) i_adcs_analog_model (.clk_i(clk_i), .ana_i(ana),
        .cmp_o(cmp));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic close_out;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Watchdog well beyond the roughly 1300 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], v);
            if (a != 2 && a != 4) check(v, 8'h00);
        end
        wr(CTRL, 8'h04);
        rd(CTRL, v);
        check(v, 8'h00);
        wr(CTRL, 8'h05);
        rd(CTRL, v);
        check(v, 8'h01);
        // Every clock select, channel equal to the select code
        for (int s = 0; s < 4; s++) begin
            wr(STAT, 8'h00);
            wr(CTRL, {s[1:0], s[2:0], 3'b001});
            wr(CTRL, {s[1:0], s[2:0], 3'b101});
            t0 = cyc;
            v = 8'h04;
            for (int k = 0; k < 600 && v[2] === 1'b1; k++) rd(CTRL, v);
            check(8'(cyc - t0 >= 18 * hv[s] && cyc - t0 <= 20 * hv[s] + 8), 8'h01);
            rd(RES, v);
            check(v, LVLS[s*8 +: 8]);
            rd(STAT, v);
            check(v & (s == 3 ? 8'h03 : 8'h07), {5'h0, s < 2, 2'b01});
            check(flag, 8'h01);
            if (hv[s] > 4) check(ana.sample, 8'h00);
            repeat (5 * hv[s]) @(posedge clk_i);
            #1 check(ana.sample, 8'h01);
        end
        // Abort keeps result, then a refused restart during the wait
        wr(RES, 8'h5a);
        wr(STAT, 8'h00);
        wr(CTRL, 8'h85);
        repeat (60) @(posedge clk_i);
        wr(CTRL, 8'h81);
        wr(CTRL, 8'h85);
        rd(CTRL, v);
        check(v, 8'h81);
        check(ana.sample, 8'h00);
        rd(RES, v);
        check(v, 8'h5a);
        rd(STAT, v);
        check(v & 8'h03, 8'h00);
        repeat (80) @(posedge clk_i);
        #1 check(ana.sample, 8'h01);
        // Sleep on a divided clock aborts and powers down
        wr(CTRL, 8'h85);
        repeat (20) @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 check(ana.power, 8'h00);
        rd(CTRL, v);
        check(v, 8'h81);
        repeat (80) @(posedge clk_i);
        sleep_i <= 1'b0;
        // Conversion in sleep on RC, with and without interrupt enable
        for (int ie = 1; ie >= 0; ie--) begin
            wr(STAT, {6'h0, ie[0], 1'b0});
            wr(CTRL, 8'hc9);
            wr(CTRL, 8'hcd);
            sleep_i <= 1'b1;
            t0 = wakes;
            repeat (70) @(posedge clk_i);
            rd(CTRL, v);
            check(v, 8'hc9);
            rd(RES, v);
            check(v, LVLS[15:8]);
            check(8'(wakes - t0), ie[7:0]);
            check(ana.power, ie[7:0]);
            @(posedge clk_i) sleep_i <= 1'b0;
            repeat (10) @(posedge clk_i);
        end
        // Divided clock sped up mid-conversion: later bits are suspect
        wr(CTRL, 8'h81);
        wr(CTRL, 8'h85);
        repeat (100) @(posedge clk_i);
        wr(CTRL, 8'h05);
        repeat (40) @(posedge clk_i);
        rd(RES, v);
        check(v, LVLS[7:0]);
        rd(STAT, v);
        check(v & 8'h04, 8'h04);
        // Reset in mid-conversion keeps the result
        wr(CTRL, 8'h85);
        repeat (30) @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(CTRL, v);
        check(v, 8'h00);
        rd(RES, v);
        check(v, LVLS[7:0]);
        // Port configuration and port read-back
        for (int p = 0; p < 4; p++) begin
            wr(`ADCS_OFF_PCFG, p[7:0]);
            rd(`ADCS_OFF_PORT, v);
            check(v, PEXP[p*8+8 +: 8]);
            check({3'h0, vref_ext, pin_analog}, AEXP[p*8+8 +: 8]);
        end
        close_out();
    end
endmodule : tb_adcs_sequencer
`default_nettype wire
